// *** hdl/mmd_map.vh ***
// Constants of the memory map decode block: I/O port, register fields, address map, bank sizes and refresh timing.
// Included by every design file of the block; holds definitions only.
`ifndef MMD_MAP_VH
`define MMD_MAP_VH

// I/O port shared by the refresh control register (write) and the presence readback (read)
`define MMD_IO_PORT_REFRESH 16'h0103
`define MMD_IO_ADDR_MSB 15

// Refresh control register
`define MMD_REFRESH_CTRL_RESET 8'h00
`define MMD_REFRESH_RATE_BIT 1
`define MMD_REFRESH_CTRL_WMASK 8'h02

// Presence readback: fixed value and its fields
`define MMD_PRESENCE_VALUE 8'hF0
`define MMD_CONN1_SIZE_LSB 0
`define MMD_CONN2_SIZE_LSB 2
`define MMD_CONN_SIZE_1MB 2'h0
`define MMD_CONN_SIZE_2MB 2'h2
`define MMD_CONN_SIZE_NONE 2'h1

// Processor address map
`define MMD_ADDR_TOP 32'hFFFFFFFF
`define MMD_LOW_RAM_END_640K 32'h0009FFFF
`define MMD_LOW_RAM_END_512K 32'h0007FFFF
`define MMD_ROM_BASE 32'h000E0000
`define MMD_ROM_END 32'h000FFFFF
`define MMD_ROM_ALIAS_BASE 32'hFFFE0000
`define MMD_EXT_BASE 32'h00100000
`define MMD_SPLIT_BYTES_384K 32'h00060000
`define MMD_SPLIT_BYTES_256K 32'h00040000
`define MMD_SPLIT_PHYS_512K 32'h00080000
`define MMD_SPLIT_PHYS_640K 32'h000A0000

// Bank size codes (two bits per bank) and their capacity in MB
`define MMD_BSIZE_256K 2'h0
`define MMD_BSIZE_1M 2'h2
`define MMD_BSIZE_4M 2'h3
`define MMD_BANK_MB_256K 7'h01
`define MMD_BANK_MB_1M 7'h04
`define MMD_BANK_MB_4M 7'h10

// Refresh interval timing
`define MMD_SYS_CLK_MHZ 50
`define MMD_REFRESH_SHORT_NS 800
`define MMD_REFRESH_LONG_NS 15100
`define MMD_REFRESH_SHORT_CYC ((`MMD_REFRESH_SHORT_NS * `MMD_SYS_CLK_MHZ) / 1000)
`define MMD_REFRESH_LONG_CYC ((`MMD_REFRESH_LONG_NS * `MMD_SYS_CLK_MHZ) / 1000)

`endif

// *** hdl/mmd_dram_mux.v ***
// DRAM address multiplexer for banks of mixed DRAM sizes.
// Assumes the bank-relative latched memory address is stable; purely combinational.
`timescale 1ns/100ps
`include "mmd_map.vh"

module mmd_dram_mux (
    input wire [25:0] latchedMemoryAddress,
    output reg [10:0] dramRowAddress,
    output reg [10:0] dramColAddress
);

    ////////////////////////////////////////////////////////////////////////////////
    // Smaller parts use a subset of the lines, so one wiring serves every size
    always @* begin
        dramColAddress[5:0] = latchedMemoryAddress[7:2];
        dramColAddress[6] = latchedMemoryAddress[9];
        dramColAddress[7] = latchedMemoryAddress[10];
        dramColAddress[8] = latchedMemoryAddress[8];
        dramColAddress[9] = latchedMemoryAddress[20];
        dramColAddress[10] = latchedMemoryAddress[22];
        dramRowAddress[8:0] = latchedMemoryAddress[19:11];
        dramRowAddress[9] = latchedMemoryAddress[21];
        dramRowAddress[10] = latchedMemoryAddress[23];
    end

endmodule // mmd_dram_mux

// *** hdl/mmd_memory_map_decode.v ***
// Memory map decode of the system board: RAM, ROM, split RAM and channel routing,
// bank selection with DRAM address multiplexing, refresh rate register and presence readback.
// Assumes the CPU local bus and the memory configuration bits come from logic on sys_clk.
//
// Behaviour
// - Lowest 640 KB decode as board RAM unless the first megabyte splits at 512 KB.
// - Enabled board memory above 1 MB is contiguous from 00100000h; channel RAM follows.
// - Split RAM of 256 or 384 KB is relocated to the programmed split address.
// - With 512 KB split, 0-7FFFFh is board RAM and 80000h-9FFFFh is unclaimed.
// - Split enabled at 512 KB places 384 KB of board RAM at the split address.
// - Split enabled at 640 KB places 256 KB of board RAM at the split address.
// - ROM selected: E0000h-FFFFFh is board ROM, aliased at FFFE0000h-FFFFFFFFh.
// - ROM deselected: E0000h-FFFFFh is board RAM; the high alias stays ROM.
// - Only the CPU reaches the configuration registers; masters and DMA are ignored.
// - Port 0103h write updates refresh control; read returns the presence value.
// - Refresh rate select clear gives 0.8 us refresh, set gives 15.1 us.
// - Refresh control resets to zero, the 0.8 us interval, until firmware reprograms it.
// - Presence readback senses nothing and always reads 11110000.
// - Connector fields at bits 1,0 and 3,2: 00 1 MB, 10 2 MB, X1 none.
// - Board memory is four sequential banks of 1, 4 or 16 MB; legacy order at reset.
// - Split at 512 KB select clear splits at 640 KB, set splits at 512 KB.
// - Split disable clear maps split memory at the split address; set disables it.
// - ROM select set: ROM reads to ROM, writes to RAM; clear: reads RAM, writes channel.
`timescale 1ns/100ps
`include "mmd_map.vh"

module mmd_memory_map_decode (
    input wire sys_clk,
    input wire rst_b,
    input wire cpuMemReq,
    input wire cpuIoReq,
    input wire cpuWrite,
    input wire cpuIsCpu,
    input wire [31:0] cpuAddr,
    input wire [7:0] cpuWrData,
    input wire split_disable,
    input wire split_at_512k_select,
    input wire rom_select,
    input wire [11:0] splitBaseMb,
    input wire [7:0] bankSizeCode,
    input wire [3:0] bankEnable,
    output reg decodeValid,
    output reg selBoardRam,
    output reg selBoardRom,
    output reg selChannel,
    output reg [1:0] dramBank,
    output reg [10:0] dramRowAddress,
    output reg [10:0] dramColAddress,
    output reg ioRdValid,
    output reg [7:0] ioRdData,
    output reg ioWrAck,
    output wire refresh_rate_select,
    output reg refreshRequest
);

    ////////////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Inclusive address window test, used by the high ROM alias and the shadow window regions
    function inRange;
        input [31:0] addr;
        input [31:0] lo;
        input [31:0] hi;
        begin
            inRange = (addr >= lo) && (addr <= hi);
        end
    endfunction

    // Capacity in MB of one bank from its size code; the reserved code counts as empty
    function [6:0] bankMb;
        input [1:0] code;
        begin
            case (code)
                `MMD_BSIZE_256K: bankMb = `MMD_BANK_MB_256K;
                `MMD_BSIZE_1M: bankMb = `MMD_BANK_MB_1M;
                `MMD_BSIZE_4M: bankMb = `MMD_BANK_MB_4M;
                default: bankMb = 7'h00;
            endcase
        end
    endfunction

    // Bank that occupies a sequential slot; legacy order walks connector 1 before connector 2
    function [1:0] slotBank;
        input legacy;
        input [1:0] slot;
        begin
            if (legacy) begin
                case (slot)
                    2'h1: slotBank = 2'h2;
                    2'h2: slotBank = 2'h1;
                    default: slotBank = slot;
                endcase
            end else begin
                slotBank = slot;
            end
        end
    endfunction

    // Size code of a bank out of the packed size bus
    function [1:0] codeOf;
        input [7:0] codes;
        input [1:0] bank;
        begin
            case (bank)
                2'h0: codeOf = codes[1:0];
                2'h1: codeOf = codes[3:2];
                2'h2: codeOf = codes[5:4];
                default: codeOf = codes[7:6];
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    reg [7:0] refreshCtrl_reg;
    reg [9:0] refreshCnt_reg;
    reg [9:0] refreshLimit;
    reg [6:0] totalMb;
    reg [31:0] extLimit;
    reg [31:0] lowRamEnd;
    reg [31:0] splitBase;
    reg [31:0] splitBytes;
    reg [31:0] splitPhys;
    reg splitHit;
    reg hitRam;
    reg hitRom;
    reg [31:0] physAddr;
    reg [1:0] bankSel;
    reg [31:0] bankOffset;
    reg [6:0] slotBase;
    reg [6:0] slotSize;
    reg bankFound;
    reg legacyMode;
    reg [1:0] slotIdx;
    integer i;
    integer k;
    wire ioHit;
    wire [10:0] muxRow;
    wire [10:0] muxCol;
    wire [7:0] presenceValue;

    ////////////////////////////////////////////////////////////////////////////////
    // Bank layout

    // All banks at the 256K code means the power-up arrangement
    always @* begin
        legacyMode = (bankSizeCode == 8'h00);
    end

    // Total enabled board memory; it sets where the extended block ends
    always @* begin
        totalMb = 7'h00;
        for (i = 0; i < 4; i = i + 1) begin
            if (bankEnable[i]) begin
                totalMb = totalMb + bankMb(codeOf(bankSizeCode, i[1:0]));
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Address map decode

    // Region limits derived from the split controls
    always @* begin
        lowRamEnd = split_at_512k_select ? `MMD_LOW_RAM_END_512K : `MMD_LOW_RAM_END_640K;
        splitBytes = split_at_512k_select ? `MMD_SPLIT_BYTES_384K : `MMD_SPLIT_BYTES_256K;
        splitPhys = split_at_512k_select ? `MMD_SPLIT_PHYS_512K : `MMD_SPLIT_PHYS_640K;
        splitBase = {splitBaseMb, 20'h00000};
        extLimit = {5'h00, totalMb, 20'h00000};
        splitHit = !split_disable && (cpuAddr >= splitBase) && (cpuAddr - splitBase < splitBytes);
    end

    // Region priority: high ROM alias, shadow window, low RAM, extended block, split block.
    // Anything left falls to the channel, including the 80000h hole of the 512 KB split.
    always @* begin
        hitRam = 1'b0;
        hitRom = 1'b0;
        physAddr = cpuAddr;
        if (inRange(cpuAddr, `MMD_ROM_ALIAS_BASE, `MMD_ADDR_TOP)) begin
            hitRom = 1'b1;
        end else if (inRange(cpuAddr, `MMD_ROM_BASE, `MMD_ROM_END)) begin
            if (rom_select) begin
                hitRom = !cpuWrite;
                hitRam = cpuWrite;
            end else begin
                hitRam = !cpuWrite;
            end
        end else if (cpuAddr <= lowRamEnd) begin
            hitRam = 1'b1;
        end else if ((cpuAddr >= `MMD_EXT_BASE) && (cpuAddr < extLimit)) begin
            hitRam = 1'b1;
        end else if (splitHit) begin
            hitRam = 1'b1;
            physAddr = splitPhys + (cpuAddr - splitBase);
        end
    end

    // Bank selection: walk the slots in order and take the first whose top lies above the address
    always @* begin
        bankSel = 2'h0;
        bankOffset = 32'h00000000;
        bankFound = 1'b0;
        slotBase = 7'h00;
        slotSize = 7'h00;
        slotIdx = 2'h0;
        for (k = 0; k < 4; k = k + 1) begin
            slotIdx = slotBank(legacyMode, k[1:0]);
            slotSize = bankEnable[slotIdx] ? bankMb(codeOf(bankSizeCode, slotIdx)) : 7'h00;
            if (!bankFound && (physAddr < {5'h00, slotBase + slotSize, 20'h00000})) begin
                bankFound = 1'b1;
                bankSel = slotIdx;
                bankOffset = physAddr - {5'h00, slotBase, 20'h00000};
            end
            slotBase = slotBase + slotSize;
        end
    end

    // Row and column lines for the selected bank
    mmd_dram_mux u_dram_mux (
        .latchedMemoryAddress(bankOffset[25:0]),
        .dramRowAddress(muxRow),
        .dramColAddress(muxCol)
    );

    // Decode result is registered so every output comes from a flop; one cycle of latency
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            decodeValid <= 1'b0;
            selBoardRam <= 1'b0;
            selBoardRom <= 1'b0;
            selChannel <= 1'b0;
            dramBank <= 2'h0;
            dramRowAddress <= 11'h000;
            dramColAddress <= 11'h000;
        end else begin
            decodeValid <= cpuMemReq;
            selBoardRam <= cpuMemReq && hitRam;
            selBoardRom <= cpuMemReq && hitRom;
            selChannel <= cpuMemReq && !hitRam && !hitRom;
            if (cpuMemReq && hitRam) begin
                dramBank <= bankSel;
                dramRowAddress <= muxRow;
                dramColAddress <= muxCol;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // I/O register at the refresh port

    // Masters and DMA cycles never match, so they neither write nor get an answer
    assign ioHit = cpuIoReq && cpuIsCpu && (cpuAddr[`MMD_IO_ADDR_MSB:0] == `MMD_IO_PORT_REFRESH);

    // Fixed presence value built from its connector fields; nothing is sensed
    assign presenceValue = (`MMD_PRESENCE_VALUE & 8'hF0)
                         | ({6'h00, `MMD_CONN_SIZE_1MB} << `MMD_CONN1_SIZE_LSB)
                         | ({6'h00, `MMD_CONN_SIZE_1MB} << `MMD_CONN2_SIZE_LSB);

    // Only the rate bit is stored, so stray reserved bits written by software do no harm
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            refreshCtrl_reg <= `MMD_REFRESH_CTRL_RESET;
            ioWrAck <= 1'b0;
            ioRdValid <= 1'b0;
            ioRdData <= 8'h00;
        end else begin
            ioWrAck <= ioHit && cpuWrite;
            ioRdValid <= ioHit && !cpuWrite;
            if (ioHit && cpuWrite) begin
                refreshCtrl_reg <= cpuWrData & `MMD_REFRESH_CTRL_WMASK;
            end
            if (ioHit && !cpuWrite) begin
                ioRdData <= presenceValue;
            end else begin
                ioRdData <= 8'h00;
            end
        end
    end

    assign refresh_rate_select = refreshCtrl_reg[`MMD_REFRESH_RATE_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // Refresh interval timer

    // Period picked by the rate bit; a change takes effect within the running period
    wire [31:0] refreshLongFull = `MMD_REFRESH_LONG_CYC - 32'h00000001;
    wire [31:0] refreshShortFull = `MMD_REFRESH_SHORT_CYC - 32'h00000001;
    always @* begin
        if (refresh_rate_select) begin
            refreshLimit = refreshLongFull[9:0];
        end else begin
            refreshLimit = refreshShortFull[9:0];
        end
    end

    // Compare with >= so a switch from the long to the short period does not overrun
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            refreshCnt_reg <= 10'h000;
            refreshRequest <= 1'b0;
        end else begin
            if (refreshCnt_reg >= refreshLimit) begin
                refreshCnt_reg <= 10'h000;
                refreshRequest <= 1'b1;
            end else begin
                refreshCnt_reg <= refreshCnt_reg + 10'h001;
                refreshRequest <= 1'b0;
            end
        end
    end

endmodule // mmd_memory_map_decode

// *** tb/mmd_cpu_model.sv ***
// Behavioural CPU on the local processor bus: drives memory and I/O cycles.
// Assumes the decode block samples requests on the rising edge of sys_clk.
`timescale 1ns/100ps

module mmd_cpu_model (
    input wire sys_clk,
    output logic cpuMemReq,
    output logic cpuIoReq,
    output logic cpuWrite,
    output logic cpuIsCpu,
    output logic [31:0] cpuAddr,
    output logic [7:0] cpuWrData
);

////////////////////////////////////////////////////////////////////////
// Idle bus at time zero
initial begin
    cpuMemReq = 1'b0;
    cpuIoReq = 1'b0;
    cpuWrite = 1'b0;
    cpuIsCpu = 1'b1;
    cpuAddr = 32'h00000000;
    cpuWrData = 8'h00;
end

////////////////////////////////////////////////////////////////////////
// One memory cycle; the released address is inverted so a stale value never looks valid
task automatic memCycle(input logic [31:0] a, input logic wr);
    @(negedge sys_clk);
    cpuMemReq = 1'b1;
    cpuWrite = wr;
    cpuAddr = a;
    @(negedge sys_clk);
    cpuMemReq = 1'b0;
    cpuAddr = ~a;
endtask

// One I/O cycle; isCpu low stands for a bus master or DMA owning the cycle
task automatic ioCycle(input logic [15:0] port, input logic wr, input logic isCpu, input logic [7:0] d);
    @(negedge sys_clk);
    cpuIoReq = 1'b1;
    cpuWrite = wr;
    cpuIsCpu = isCpu;
    cpuAddr = {16'h0000, port};
    cpuWrData = d;
    @(negedge sys_clk);
    cpuIoReq = 1'b0;
    cpuIsCpu = 1'b1;
    cpuAddr = ~cpuAddr;
    cpuWrData = ~d;
endtask

endmodule // mmd_cpu_model

// *** tb/mmd_decode_assertions.sv ***
// Concurrent checks on the ports of the memory map decode block.
// Assumes a single sys_clk domain with asynchronous active-low rst_b.
`timescale 1ns/100ps

module mmd_decode_assertions (
    input logic sys_clk,
    input logic rst_b,
    input logic cpuMemReq,
    input logic cpuIoReq,
    input logic cpuWrite,
    input logic cpuIsCpu,
    input logic [31:0] cpuAddr,
    input logic [7:0] cpuWrData,
    input logic split_at_512k_select,
    input logic rom_select,
    input logic decodeValid,
    input logic selBoardRam,
    input logic selBoardRom,
    input logic selChannel,
    input logic ioRdValid,
    input logic [7:0] ioRdData,
    input logic ioWrAck,
    input logic refresh_rate_select
);

default clocking cb @(posedge sys_clk);
endclocking
default disable iff (!rst_b);

////////////////////////////////////////////////////////////////////////
// Request qualifiers
wire ioHit = cpuIoReq && cpuIsCpu && cpuAddr[15:0] == 16'h0103;
wire inShadow = cpuAddr >= 32'h000E0000 && cpuAddr <= 32'h000FFFFF;
wire inHole = cpuAddr >= 32'h00080000 && cpuAddr <= 32'h0009FFFF;

////////////////////////////////////////////////////////////////////////
// Memory routing; a second route in the same cycle would double-drive the bus
dec_latency_a: assert property (cpuMemReq |=> decodeValid)
    else $error("decode answer missing");
one_route_a: assert property (decodeValid |-> $onehot({selBoardRam, selBoardRom, selChannel}))
    else $error("route not one-hot");
rom_alias_a: assert property (cpuMemReq && cpuAddr >= 32'hFFFE0000 |=> selBoardRom)
    else $error("high alias not ROM");
shadow_read_a: assert property (cpuMemReq && !cpuWrite && inShadow && rom_select |=> selBoardRom)
    else $error("shadow read not ROM");
low_ram_a: assert property (cpuMemReq && cpuAddr < 32'h00080000 |=> selBoardRam)
    else $error("low memory not RAM");
hole_512_a: assert property (cpuMemReq && split_at_512k_select && inHole |=> selChannel)
    else $error("unclaimed hole claimed");

////////////////////////////////////////////////////////////////////////
// Shared I/O port
io_read_a: assert property (ioHit && !cpuWrite |=> ioRdValid && ioRdData == 8'hF0)
    else $error("readback wrong");
io_refuse_a: assert property (cpuIoReq && !cpuIsCpu |=> !ioWrAck && !ioRdValid)
    else $error("non-CPU cycle answered");
rate_write_a: assert property (ioHit && cpuWrite |=> ioWrAck && refresh_rate_select == $past(cpuWrData[1]))
    else $error("rate bit not written");
rate_hold_a: assert property (!(ioHit && cpuWrite) |=> $stable(refresh_rate_select))
    else $error("rate bit changed");

endmodule // mmd_decode_assertions

bind mmd_memory_map_decode mmd_decode_assertions checker_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .cpuMemReq(cpuMemReq), .cpuIoReq(cpuIoReq), .cpuWrite(cpuWrite), .cpuIsCpu(cpuIsCpu),
    .cpuAddr(cpuAddr), .cpuWrData(cpuWrData), .split_at_512k_select(split_at_512k_select),
    .rom_select(rom_select), .decodeValid(decodeValid), .selBoardRam(selBoardRam),
    .selBoardRom(selBoardRom), .selChannel(selChannel), .ioRdValid(ioRdValid), .ioRdData(ioRdData),
    .ioWrAck(ioWrAck), .refresh_rate_select(refresh_rate_select));

// *** tb/mmd_memory_map_decode_tb_top.sv ***
// Self-checking bench of the memory map decode block with a CPU bus model.
// Assumes inputs change at the falling edge and outputs answer one cycle after a request.
`timescale 1ns/100ps

module mmd_memory_map_decode_tb_top;

localparam logic [2:0] RAM = 3'h4;
localparam logic [2:0] ROM = 3'h2;
localparam logic [2:0] CHN = 3'h1;
logic sys_clk = 1'b0;
logic rst_b = 1'b0;
logic split_disable = 1'b1;
logic split_at_512k_select = 1'b0;
logic rom_select = 1'b1;
logic [11:0] splitBaseMb = 12'h010;
logic [7:0] bankSizeCode = 8'h00;
logic [3:0] bankEnable = 4'h3;
wire cpuMemReq, cpuIoReq, cpuWrite, cpuIsCpu, decodeValid, selBoardRam, selBoardRom, selChannel;
wire ioRdValid, ioWrAck, refresh_rate_select, refreshRequest;
wire [31:0] cpuAddr;
wire [7:0] cpuWrData, ioRdData;
wire [1:0] dramBank;
wire [10:0] dramRowAddress, dramColAddress;
int nErrors = 0;
int checked = 0;

mmd_cpu_model mmd_cpu_model_i (.sys_clk(sys_clk), .cpuMemReq(cpuMemReq), .cpuIoReq(cpuIoReq),
    .cpuWrite(cpuWrite), .cpuIsCpu(cpuIsCpu), .cpuAddr(cpuAddr), .cpuWrData(cpuWrData));

mmd_memory_map_decode mmd_memory_map_decode_i (.sys_clk(sys_clk), .rst_b(rst_b), .cpuMemReq(cpuMemReq),
    .cpuIoReq(cpuIoReq), .cpuWrite(cpuWrite), .cpuIsCpu(cpuIsCpu), .cpuAddr(cpuAddr), .cpuWrData(cpuWrData),
    .split_disable(split_disable), .split_at_512k_select(split_at_512k_select), .rom_select(rom_select),
    .splitBaseMb(splitBaseMb), .bankSizeCode(bankSizeCode), .bankEnable(bankEnable),
    .decodeValid(decodeValid), .selBoardRam(selBoardRam), .selBoardRom(selBoardRom), .selChannel(selChannel),
    .dramBank(dramBank), .dramRowAddress(dramRowAddress), .dramColAddress(dramColAddress),
    .ioRdValid(ioRdValid), .ioRdData(ioRdData), .ioWrAck(ioWrAck),
    .refresh_rate_select(refresh_rate_select), .refreshRequest(refreshRequest));

////////////////////////////////////////////////////////////////////////
// 50 MHz clock
initial begin
    forever #10 sys_clk = ~sys_clk;
end

////////////////////////////////////////////////////////////////////////
// Comparison and verdict
task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
        nErrors++;
        $display("wrong value at %0t: %s got %0h expected %0h", $time, msg, got, exp);
    end
endtask

task automatic results();
    if (nErrors == 0 && checked > 0) begin
        $display("verification passed");
    end else begin
        $display("verification failed");
    end
    $finish;
endtask

// One memory cycle and its single route
task automatic memChk(input logic [31:0] a, input logic wr, input logic [2:0] exp);
    mmd_cpu_model_i.memCycle(a, wr);
    cmp({decodeValid, selBoardRam, selBoardRom, selChannel}, {1'b1, exp}, "route");
endtask

// Cycles between two refresh pulses, bounded so a dead counter cannot hang the run
task automatic gapChk(input int exp);
    int n;
    n = 0;
    while (refreshRequest !== 1'b1 && n < 2000) begin
        @(negedge sys_clk);
        n++;
    end
    n = 0;
    do begin
        @(negedge sys_clk);
        n++;
    end while (refreshRequest !== 1'b1 && n < 2000);
    cmp(n, exp, "refresh gap");
endtask

////////////////////////////////////////////////////////////////////////
// Scenarios
task automatic testIo();
    cmp(refresh_rate_select, 1'b0, "rate at reset");
    gapChk(40);
    mmd_cpu_model_i.ioCycle(16'h0103, 1'b0, 1'b1, 8'h00);
    cmp({ioRdValid, ioRdData}, 9'h1F0, "readback");
    cmp({ioRdData[3:2], ioRdData[1:0]}, 4'h0, "connector fields");
    mmd_cpu_model_i.ioCycle(16'h0103, 1'b1, 1'b0, 8'h02);
    cmp({ioWrAck, refresh_rate_select}, 2'h0, "master write");
    mmd_cpu_model_i.ioCycle(16'h0102, 1'b1, 1'b1, 8'h02);
    cmp({ioWrAck, refresh_rate_select}, 2'h0, "other port");
    mmd_cpu_model_i.ioCycle(16'h0103, 1'b1, 1'b1, 8'h02);
    cmp({ioWrAck, refresh_rate_select}, 2'h3, "rate write");
    gapChk(755);
    rst_b = 1'b0;
    @(negedge sys_clk);
    cmp({refresh_rate_select, refreshRequest}, 2'h0, "rate after reset");
    rst_b = 1'b1;
    gapChk(40);
endtask

task automatic testLow();
    memChk(32'h0009FFFF, 1'b0, RAM);
    memChk(32'h000A0000, 1'b0, CHN);
    split_at_512k_select = 1'b1;
    memChk(32'h0007FFFF, 1'b1, RAM);
    memChk(32'h00080000, 1'b0, CHN);
    memChk(32'h0009FFFF, 1'b0, CHN);
    split_at_512k_select = 1'b0;
endtask

task automatic testShadow();
    memChk(32'h000E0000, 1'b0, ROM);
    memChk(32'h000FFFFF, 1'b1, RAM);
    memChk(32'hFFFE0000, 1'b0, ROM);
    rom_select = 1'b0;
    memChk(32'h000E0000, 1'b0, RAM);
    memChk(32'h000E0000, 1'b1, CHN);
    memChk(32'hFFFFFFFF, 1'b0, ROM);
    rom_select = 1'b1;
endtask

task automatic testExt();
    memChk(32'h00000100, 1'b0, RAM);
    cmp(dramBank, 2'h0, "bank low");
    memChk(32'h00100000, 1'b0, RAM);
    cmp(dramBank, 2'h1, "legacy bank order");
    memChk(32'h001FFFFF, 1'b1, RAM);
    memChk(32'h00200000, 1'b0, CHN);
    memChk(32'h01000000, 1'b0, CHN);
    split_disable = 1'b0;
    memChk(32'h0103FFFF, 1'b0, RAM);
    memChk(32'h01040000, 1'b0, CHN);
    split_at_512k_select = 1'b1;
    memChk(32'h0105FFFF, 1'b1, RAM);
    memChk(32'h01060000, 1'b0, CHN);
    split_disable = 1'b1;
    split_at_512k_select = 1'b0;
endtask

task automatic testDram();
    bankSizeCode = 8'h03;
    bankEnable = 4'h1;
    memChk(32'h00000B04, 1'b0, RAM);
    cmp({dramColAddress, dramRowAddress}, {11'h141, 11'h001}, "small mux");
    memChk(32'h00F00000, 1'b0, RAM);
    cmp({dramColAddress, dramRowAddress}, {11'h600, 11'h600}, "large mux");
    bankSizeCode = 8'h00;
    bankEnable = 4'h3;
endtask

////////////////////////////////////////////////////////////////////////
// Main sequence and watchdog
initial begin
    repeat (20) @(negedge sys_clk);
    rst_b = 1'b1;
    testIo();
    testLow();
    testShadow();
    testExt();
    testDram();
    results();
end

initial begin
    #400000;
    nErrors++;
    results();
end

endmodule // mmd_memory_map_decode_tb_top
